// ### vof_pkg.sv
// Purpose: shared constants, types and line formats of the video output formatter
// Assumes: registers are 8 bits wide at 8-bit offsets on a plain strobe port
// Notes: register map, reset values, stream words and line formats of the formatter live here
package vof_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PRIMARY_MODE = 8'h00;
  localparam logic [7:0] OFF_THIRD_MODE = 8'h02;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_VBI_FLAGS = 8'h21;
  localparam logic [7:0] OFF_CLAMP_CTRL = 8'h30;
  localparam logic [7:0] OFF_CLAMP_START = 8'h31;
  localparam logic [7:0] OFF_CLAMP_END = 8'h32;
  localparam logic [7:0] RST_PRIMARY_MODE = 8'h40;
  localparam logic [7:0] RST_THIRD_MODE = 8'h00;
  localparam logic [7:0] RST_CLAMP_CTRL = 8'h00;
  localparam logic [7:0] RST_CLAMP_START = 8'h04;
  localparam logic [7:0] RST_CLAMP_END = 8'h20;
  localparam int unsigned PM_REGSEL_BIT = 0;
  localparam int unsigned PM_SAMP_LSB = 1;
  localparam int unsigned PM_OUT_LSB = 6;
  localparam int unsigned TM_VBI_V_BIT = 3;
  localparam int unsigned TM_411_BIT = 5;
  localparam int unsigned CC_EN_BIT = 0;
  // ----------------------------------------------------------------
  // stream words and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] TRS_PREAMBLE = 8'hFF;
  localparam logic [7:0] TRS_ZERO = 8'h00;
  localparam logic TRS_FIXED_ONE = 1'b1;
  localparam logic [11:0] TRS_WORDS = 12'h004;
  localparam logic [7:0] BLANK_Y = 8'h10;
  localparam logic [7:0] BLANK_C = 8'h80;
  localparam logic [11:0] HSYNC_W_PX = 12'h040;
  localparam logic [11:0] NTSC_601_WORDS = 12'h6B4;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OUT_EMBED = 2'h0,
    OUT_YC8 = 2'h1,
    OUT_YC16 = 2'h2,
    OUT_RGB = 2'h3
  } vof_out_mode_t;
  typedef enum logic [2:0] {
    SAMP_525_601 = 3'h0,
    SAMP_525_SQ = 3'h1,
    SAMP_525_4FSC = 3'h2,
    SAMP_625_601 = 3'h4,
    SAMP_625_SQ = 3'h5
  } vof_samp_t;
  typedef enum logic [1:0] {
    RG_ACT = 2'h0,
    RG_EAV = 2'h1,
    RG_BLK = 2'h3,
    RG_SAV = 2'h2
  } vof_region_t;
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
  } vof_ycc_t;
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } vof_rgb_t;
  typedef struct packed {
    logic [10:0] total;
    logic [10:0] active;
    logic [10:0] fporch;
  } vof_line_t;
  typedef struct packed {
    logic [1:0] out_mode;
    logic sleep;
    logic fm_mode;
    logic [2:0] samp;
    logic single_rate;
  } vof_status_t;

  function automatic vof_line_t vof_line_fmt(input vof_samp_t s);
    vof_line_t f;
    unique case (s)
      SAMP_525_601: f = '{total: 11'h35A, active: 11'h2D0, fporch: 11'h010};
      SAMP_525_SQ: f = '{total: 11'h30C, active: 11'h280, fporch: 11'h01C};
      SAMP_525_4FSC: f = '{total: 11'h38E, active: 11'h300, fporch: 11'h008};
      SAMP_625_601: f = '{total: 11'h360, active: 11'h2D0, fporch: 11'h00C};
      SAMP_625_SQ: f = '{total: 11'h3B0, active: 11'h300, fporch: 11'h022};
      default: f = '{total: 11'h35A, active: 11'h2D0, fporch: 11'h010};
    endcase
    return f;
  endfunction : vof_line_fmt
endpackage : vof_pkg

// ### vof_sink.sv
// Purpose: downstream receiver of the embedded stream
// Assumes: a word is taken at the rising link edge after it was launched
// Notes: gap excludes the three preamble words of a code
module vof_sink
(
  input wire logic link_clk_i,
  input wire logic [7:0] data_i,
  output logic [7:0] code_o,
  output int n_code_o,
  output int gap_o,
  output int bad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] hist = 24'h0;
  logic blank = 1'b0;
  int cnt = 0;
  initial n_code_o = 0;
  initial bad_o = 0;
  always @(posedge link_clk_i)
  begin
    hist <= {hist[15:0], data_i};
    cnt <= cnt + 1;
    if (hist == 24'hFF0000)
    begin
      code_o <= data_i;
      n_code_o <= n_code_o + 1;
      gap_o <= cnt - 3;
      cnt <= 0;
      blank <= data_i[4];
    end
    // preamble words of the next code also pass here
    else if (blank && !(data_i inside {8'h80, 8'h10, 8'hFF, 8'h00}))
      bad_o <= bad_o + 1;
  end
endmodule : vof_sink

// ### vof_sync2.sv
// Purpose: two-flop synchroniser for pins and the pixel clock
// Assumes: each bit is an independent level
// Notes: the first stage feeds only the second
module vof_sync2 #(
  parameter int unsigned WIDTH = 8
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_ff;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("vof_sync2 needs WIDTH of at least 1");
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule : vof_sync2

// ### vof_top.sv
// Purpose: output formatter of the video decoder
// Assumes: pixel data and flags come from logic on clk_i; pins and pixel clock do not
// Notes: one output word per rising pixel clock edge, every second edge in wide double-rate modes, found by oversampling
//
// The address map and the strobed register port were left to the implementer.
module vof_top
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  input wire logic link_clk_i,
  input wire logic [3:0] mode_pins_i,
  input wire logic clock_rate_select_i,
  input wire logic sleep_i,
  input wire logic external_frame_store_mode_i,
  input wire vof_pkg::vof_ycc_t pix_i,
  input wire vof_pkg::vof_rgb_t rgb_i,
  input wire logic field_i,
  input wire logic vblank_i,
  input wire logic vsync_int_i,
  input wire logic line_sync_i,
  input wire logic vbi_line_i,
  input wire logic [3:0] vbi_flags_i,
  output logic [23:0] out_data_o,
  output logic hsync_n_o,
  output logic vsync_n_o,
  output logic double_rate_clock_out_o,
  output logic clamp_window_pulse_o,
  output logic vbi_detect_pin_o,
  output logic fm_write_reset_o,
  output logic fm_read_reset_o,
  output logic fm_write_enable_o,
  output logic fm_read_strobe_o
);
  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [7:0] pin_raw;
  logic [7:0] pin_s;
  logic link_s;
  logic [3:0] mode_pins_s;
  logic clk_single_s;
  logic sleep_s;
  logic fm_s;

  assign pin_raw = {link_clk_i, mode_pins_i, clock_rate_select_i, sleep_i,
                    external_frame_store_mode_i};

  vof_sync2 #(.WIDTH(8)) u_sync
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  assign link_s = pin_s[7];
  assign mode_pins_s = pin_s[6:3];
  assign clk_single_s = pin_s[2];
  assign sleep_s = pin_s[1];
  assign fm_s = pin_s[0];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] pm_ff;
  logic [7:0] tm_ff;
  logic [7:0] cc_ff;
  logic [7:0] cs_ff;
  logic [7:0] ce_ff;
  logic [7:0] rdata_ff;
  logic [3:0] vbi_flags_ff;
  vof_pkg::vof_status_t status;
  vof_pkg::vof_out_mode_t eff_out;
  vof_pkg::vof_samp_t eff_samp;
  logic [2:0] reg_samp;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pm_ff <= vof_pkg::RST_PRIMARY_MODE;
      tm_ff <= vof_pkg::RST_THIRD_MODE;
      cc_ff <= vof_pkg::RST_CLAMP_CTRL;
      cs_ff <= vof_pkg::RST_CLAMP_START;
      ce_ff <= vof_pkg::RST_CLAMP_END;
    end
    else if (reg_we_i)
    begin
      case (reg_addr_i)
        vof_pkg::OFF_PRIMARY_MODE: pm_ff <= reg_wdata_i;
        vof_pkg::OFF_THIRD_MODE: tm_ff <= reg_wdata_i;
        vof_pkg::OFF_CLAMP_CTRL: cc_ff <= reg_wdata_i;
        vof_pkg::OFF_CLAMP_START: cs_ff <= reg_wdata_i;
        vof_pkg::OFF_CLAMP_END: ce_ff <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  assign status = '{out_mode: eff_out, sleep: sleep_s, fm_mode: fm_s, samp: eff_samp,
                    single_rate: clk_single_s};

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= 8'h00;
    end
    else if (reg_re_i)
    begin
      case (reg_addr_i)
        vof_pkg::OFF_PRIMARY_MODE: rdata_ff <= pm_ff;
        vof_pkg::OFF_THIRD_MODE: rdata_ff <= tm_ff;
        vof_pkg::OFF_STATUS: rdata_ff <= status;
        vof_pkg::OFF_VBI_FLAGS: rdata_ff <= {4'h0, vbi_flags_ff};
        vof_pkg::OFF_CLAMP_CTRL: rdata_ff <= cc_ff;
        vof_pkg::OFF_CLAMP_START: rdata_ff <= cs_ff;
        vof_pkg::OFF_CLAMP_END: rdata_ff <= ce_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
    begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------
  always_comb
  begin
    reg_samp = pm_ff[vof_pkg::PM_SAMP_LSB +: 3];
    if (pm_ff[vof_pkg::PM_REGSEL_BIT])
    begin
      eff_out = vof_pkg::vof_out_mode_t'(pm_ff[vof_pkg::PM_OUT_LSB +: 2]);
      case (reg_samp)
        vof_pkg::SAMP_525_601, vof_pkg::SAMP_525_SQ, vof_pkg::SAMP_525_4FSC,
        vof_pkg::SAMP_625_601, vof_pkg::SAMP_625_SQ:
          eff_samp = vof_pkg::vof_samp_t'(reg_samp);
        default: eff_samp = vof_pkg::SAMP_525_601;
      endcase
    end
    else
    begin
      eff_out = vof_pkg::vof_out_mode_t'(mode_pins_s[3:2]);
      // middle bit forced low so pins never reach 4fsc
      eff_samp = vof_pkg::vof_samp_t'({mode_pins_s[1], 1'b0, mode_pins_s[0]});
    end
  end

  // ----------------------------------------------------------------
  // line timing
  // ----------------------------------------------------------------
  vof_pkg::vof_line_t fmt;
  vof_pkg::vof_region_t region_ff;
  vof_pkg::vof_region_t nxt_region;
  logic wide;
  logic [11:0] line_len;
  logic [11:0] act_len;
  logic [11:0] hs_start;
  logic [11:0] hc_ff;
  logic [11:0] nxt_hc;
  logic [11:0] nxt_px;
  logic [11:0] px_off;
  logic link_q_ff;
  logic half_ff;
  logic sync_pend_ff;
  logic wstb;
  logic tick;
  logic wrap;

  assign fmt = vof_pkg::vof_line_fmt(eff_samp);
  assign wide = (eff_out == vof_pkg::OUT_YC16) || (eff_out == vof_pkg::OUT_RGB);
  assign line_len = wide ? {1'b0, fmt.total} : {fmt.total, 1'b0};
  assign act_len = wide ? {1'b0, fmt.active} : {fmt.active, 1'b0};
  assign hs_start = {1'b0, fmt.active} + {1'b0, fmt.fporch};
  assign wstb = link_s & ~link_q_ff;
  // wide modes on a double-rate clock take every second edge
  assign tick = wstb & ~sleep_s & (~wide | clk_single_s | half_ff);
  assign wrap = sync_pend_ff | line_sync_i | (hc_ff >= line_len - 12'h001);
  assign nxt_hc = wrap ? 12'h000 : hc_ff + 12'h001;
  assign nxt_px = wide ? nxt_hc : {1'b0, nxt_hc[11:1]};
  assign px_off = nxt_px - hs_start;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link_q_ff <= 1'b0;
      half_ff <= 1'b0;
      sync_pend_ff <= 1'b0;
    end
    else
    begin
      link_q_ff <= link_s;
      half_ff <= wstb ? ~half_ff : half_ff;
      // a restart arriving on a tick is used by that tick, never dropped
      sync_pend_ff <= ~tick & (line_sync_i | sync_pend_ff);
    end
  end

  // in the 8-bit modes active counts and line lengths are multiples of four, so hc[1:0] indexes code words
  always_comb
  begin
    if (nxt_hc < act_len)
      nxt_region = vof_pkg::RG_ACT;
    else if (nxt_hc < act_len + vof_pkg::TRS_WORDS)
      nxt_region = vof_pkg::RG_EAV;
    else if (nxt_hc >= line_len - vof_pkg::TRS_WORDS)
      nxt_region = vof_pkg::RG_SAV;
    else
      nxt_region = vof_pkg::RG_BLK;
  end

  // ----------------------------------------------------------------
  // word formatting
  // ----------------------------------------------------------------
  logic trs_v;
  logic [7:0] trs_word;
  logic [7:0] chroma;
  logic [1:0] cb_pair;
  logic [1:0] cr_pair;
  logic [23:0] nxt_word;
  logic [23:0] out_data_ff;
  logic trs_f_ff;
  logic trs_v_ff;
  logic emb_ff;

  assign trs_v = vblank_i & ~(tm_ff[vof_pkg::TM_VBI_V_BIT] & vbi_line_i);

  vof_trs u_trs
  (
    .field_i(field_i),
    .vflag_i(trs_v),
    .hflag_i(nxt_region == vof_pkg::RG_EAV),
    .word_o(trs_word)
  );

  always_comb
  begin
    cb_pair = 2'(pix_i.cb >> {~nxt_px[1:0], 1'b0});
    cr_pair = 2'(pix_i.cr >> {~nxt_px[1:0], 1'b0});
    if (tm_ff[vof_pkg::TM_411_BIT])
      chroma = {cb_pair, cr_pair, 4'h0};
    else
      chroma = nxt_px[0] ? pix_i.cr : pix_i.cb;
    nxt_word = 24'h000000;
    unique case (eff_out)
      vof_pkg::OUT_EMBED, vof_pkg::OUT_YC8:
      begin
        if (nxt_region == vof_pkg::RG_ACT)
        begin
          unique case (nxt_hc[1:0])
            2'h0: nxt_word[7:0] = pix_i.cb;
            2'h2: nxt_word[7:0] = pix_i.cr;
            default: nxt_word[7:0] = pix_i.y;
          endcase
        end
        else if (eff_out == vof_pkg::OUT_EMBED && nxt_region != vof_pkg::RG_BLK)
        begin
          unique case (nxt_hc[1:0])
            2'h0: nxt_word[7:0] = vof_pkg::TRS_PREAMBLE;
            2'h3: nxt_word[7:0] = trs_word;
            default: nxt_word[7:0] = vof_pkg::TRS_ZERO;
          endcase
        end
        else
        begin
          nxt_word[7:0] = nxt_hc[0] ? vof_pkg::BLANK_Y : vof_pkg::BLANK_C;
        end
      end
      vof_pkg::OUT_YC16:
      begin
        if (nxt_region == vof_pkg::RG_ACT)
          nxt_word[15:0] = {pix_i.y, chroma};
        else
          nxt_word[15:0] = {vof_pkg::BLANK_Y, vof_pkg::BLANK_C};
      end
      vof_pkg::OUT_RGB:
      begin
        if (nxt_region == vof_pkg::RG_ACT)
          nxt_word = rgb_i;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hc_ff <= 12'h000;
      region_ff <= vof_pkg::RG_ACT;
      out_data_ff <= 24'h000000;
      trs_f_ff <= 1'b0;
      trs_v_ff <= 1'b0;
      emb_ff <= 1'b0;
    end
    else if (sleep_s)
    begin
      out_data_ff <= 24'h000000;
      // a cleared word is neither code nor blanking until the next tick
      emb_ff <= 1'b0;
    end
    else if (tick)
    begin
      hc_ff <= nxt_hc;
      region_ff <= nxt_region;
      out_data_ff <= nxt_word;
      trs_f_ff <= field_i;
      trs_v_ff <= trs_v;
      emb_ff <= eff_out == vof_pkg::OUT_EMBED;
    end
  end

  assign out_data_o = out_data_ff;

  // ----------------------------------------------------------------
  // syncs, clamp, clock out, frame store
  // ----------------------------------------------------------------
  logic hs_n_ff;
  logic vs_pend_ff;
  logic vs_out_ff;
  logic clamp_ff;
  logic clamp_win;
  logic dclk_ff;
  logic vbi_pin_ff;
  logic wr_rst_ff;
  logic rd_rst_ff;
  logic fm_we_ff;
  logic fm_re_ff;

  assign clamp_win = (px_off >= {4'h0, cs_ff}) && (px_off < {4'h0, ce_ff});

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hs_n_ff <= 1'b1;
      clamp_ff <= 1'b0;
    end
    else
    begin
      if (tick)
        hs_n_ff <= ~(nxt_px >= hs_start && nxt_px < hs_start + vof_pkg::HSYNC_W_PX);
      clamp_ff <= cc_ff[vof_pkg::CC_EN_BIT] & ~sleep_s & (tick ? clamp_win : clamp_ff);
    end
  end

  // internal vertical sync is taken one line ahead of its output
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      vs_pend_ff <= 1'b0;
      vs_out_ff <= 1'b0;
      wr_rst_ff <= 1'b0;
      rd_rst_ff <= 1'b0;
    end
    else if (tick && wrap)
    begin
      vs_pend_ff <= vsync_int_i;
      vs_out_ff <= vs_pend_ff;
      wr_rst_ff <= fm_s & vsync_int_i & ~vs_pend_ff;
      rd_rst_ff <= fm_s & vs_pend_ff & ~vs_out_ff;
    end
    else if (!fm_s || sleep_s)
    begin
      wr_rst_ff <= 1'b0;
      rd_rst_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dclk_ff <= 1'b0;
      vbi_pin_ff <= 1'b0;
      vbi_flags_ff <= 4'h0;
      fm_we_ff <= 1'b0;
      fm_re_ff <= 1'b0;
    end
    else
    begin
      dclk_ff <= link_s & ~sleep_s;
      vbi_pin_ff <= |vbi_flags_i;
      vbi_flags_ff <= vbi_flags_i;
      fm_we_ff <= fm_s & ~sleep_s & ~vblank_i & (region_ff == vof_pkg::RG_ACT);
      fm_re_ff <= fm_s & ~sleep_s & ~vblank_i & (region_ff == vof_pkg::RG_ACT);
    end
  end

  assign hsync_n_o = hs_n_ff;
  assign vsync_n_o = ~vs_out_ff;
  assign double_rate_clock_out_o = dclk_ff;
  assign clamp_window_pulse_o = clamp_ff;
  assign vbi_detect_pin_o = vbi_pin_ff;
  assign fm_write_reset_o = wr_rst_ff;
  assign fm_read_reset_o = rd_rst_ff;
  assign fm_write_enable_o = fm_we_ff;
  assign fm_read_strobe_o = fm_re_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic code_ff;
  assign code_ff = emb_ff && (region_ff == vof_pkg::RG_EAV || region_ff == vof_pkg::RG_SAV);

  default clocking cb_main @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_trs_preamble;
    code_ff && hc_ff[1:0] == 2'h0 && !sleep_s |-> out_data_ff[7:0] == 8'hFF;
  endproperty
  a_trs_preamble: assert property (p_trs_preamble) else $error("code word 0 not FF");

  property p_trs_zero;
    code_ff && hc_ff[1] != hc_ff[0] && !sleep_s |-> out_data_ff[7:0] == 8'h00;
  endproperty
  a_trs_zero: assert property (p_trs_zero) else $error("code words 1-2 not zero");

  property p_trs_flags;
    code_ff && hc_ff[1:0] == 2'h3 && !sleep_s
      |-> out_data_ff[7] && out_data_ff[6] == trs_f_ff && out_data_ff[5] == trs_v_ff;
  endproperty
  a_trs_flags: assert property (p_trs_flags) else $error("status word flags wrong");

  property p_trs_h;
    code_ff && hc_ff[1:0] == 2'h3 && !sleep_s
      |-> out_data_ff[4] == (region_ff == vof_pkg::RG_EAV);
  endproperty
  a_trs_h: assert property (p_trs_h) else $error("start/end flag wrong");

  // plain table, kept apart from the xor form of the encoder
  logic [3:0] prot_ref;
  always_comb
  begin
    unique case (out_data_ff[6:4])
      3'h0: prot_ref = 4'h0;
      3'h1: prot_ref = 4'hD;
      3'h2: prot_ref = 4'hB;
      3'h3: prot_ref = 4'h6;
      3'h4: prot_ref = 4'h7;
      3'h5: prot_ref = 4'hA;
      3'h6: prot_ref = 4'hC;
      3'h7: prot_ref = 4'h1;
    endcase
  end

  property p_trs_prot;
    code_ff && hc_ff[1:0] == 2'h3 && !sleep_s |-> out_data_ff[3:0] == prot_ref;
  endproperty
  a_trs_prot: assert property (p_trs_prot) else $error("protection bits wrong");

  property p_vbi_v;
    tick && tm_ff[vof_pkg::TM_VBI_V_BIT] && vbi_line_i |=> !trs_v_ff;
  endproperty
  a_vbi_v: assert property (p_vbi_v) else $error("VBI line kept V=1");

  property p_blank;
    emb_ff && region_ff == vof_pkg::RG_BLK && !sleep_s
      |-> out_data_ff[7:0] == 8'h10 || out_data_ff[7:0] == 8'h80;
  endproperty
  a_blank: assert property (p_blank) else $error("blanking word not blank value");

  property p_line_len;
    eff_samp == vof_pkg::SAMP_525_601 && !wide |-> line_len == vof_pkg::NTSC_601_WORDS;
  endproperty
  a_line_len: assert property (p_line_len) else $error("525 line not 1716 words");

  property p_pin_mode;
    !pm_ff[0] |-> eff_samp != vof_pkg::SAMP_525_4FSC && eff_out == mode_pins_s[3:2];
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin mode misapplied");

  property p_sleep;
    sleep_s |=> out_data_ff == 24'h000000 && !clamp_ff && !fm_we_ff;
  endproperty
  a_sleep: assert property (p_sleep) else $error("outputs active in sleep");

  property p_fm_idle;
    !fm_s ##1 !fm_s |-> !fm_we_ff && !fm_re_ff && !wr_rst_ff && !rd_rst_ff;
  endproperty
  a_fm_idle: assert property (p_fm_idle) else $error("memory strobe outside frame store");

  property p_vs_delay;
    tick && wrap |=> vs_out_ff == $past(vs_pend_ff);
  endproperty
  a_vs_delay: assert property (p_vs_delay) else $error("vertical sync not one line late");

  c_eav: cover property (code_ff && region_ff == vof_pkg::RG_EAV && hc_ff[1:0] == 2'h3);
  c_sav_vblank: cover property (code_ff && region_ff == vof_pkg::RG_SAV && trs_v_ff);
  c_wide_pixel: cover property (tick && wide && !clk_single_s);
  c_fm_reset: cover property (wr_rst_ff);
endmodule : vof_top

// ### vof_top_tb.sv
// Purpose: self-checking bench of the output formatter
// Assumes: register port strobes, free running 80 ns link clock
// Notes: five embedded lines take most of the run
module vof_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ra = 8'h00;
  logic [7:0] wd = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic lk = 1'b0;
  logic slp = 1'b0;
  logic fld = 1'b0;
  logic vb = 1'b0;
  logic ls = 1'b0;
  logic vl = 1'b0;
  logic [3:0] vf = 4'h0;
  vof_pkg::vof_ycc_t pix = '0;
  vof_pkg::vof_rgb_t rgb = '0;
  logic [7:0] rd;
  logic [23:0] od;
  logic drc;
  logic vpin;
  logic [7:0] code;
  logic hs, vsn, cw, wr, rr, fwe, fre;
  logic vsi = 1'b0;
  logic fm = 1'b1;
  int n_hs = 0, n_cl = 0, n_fm = 0, h0, c0, w0;
  // one pixel is two link words of eight system clocks
  localparam int CLK_PER_PX = 16;
  localparam int CLAMP_CLKS = (vof_pkg::RST_CLAMP_END - vof_pkg::RST_CLAMP_START) * CLK_PER_PX;
  int n_code, gap, bad, base, b0;
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'hAB220EEF;
  vof_top DUT (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd), .link_clk_i(lk),
    .mode_pins_i(4'h4), .clock_rate_select_i(1'b0), .sleep_i(slp),
    .external_frame_store_mode_i(fm), .pix_i(pix), .rgb_i(rgb), .field_i(fld),
    .vblank_i(vb), .vsync_int_i(vsi), .line_sync_i(ls), .vbi_line_i(vl),
    .vbi_flags_i(vf), .out_data_o(od), .hsync_n_o(hs), .vsync_n_o(vsn),
    .double_rate_clock_out_o(drc), .clamp_window_pulse_o(cw), .vbi_detect_pin_o(vpin),
    .fm_write_reset_o(wr), .fm_read_reset_o(rr), .fm_write_enable_o(fwe),
    .fm_read_strobe_o(fre));
  vof_sink sink (.link_clk_i(lk), .data_i(od[7:0]), .code_o(code), .n_code_o(n_code),
    .gap_o(gap), .bad_o(bad));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] exp_code(input logic f, v, h);
    logic [3:0] p [8] = '{4'h0, 4'hD, 4'hB, 4'h6, 4'h7, 4'hA, 4'hC, 4'h1};
    return {1'b1, f, v, h, p[{f, v, h}]};
  endfunction : exp_code
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge clk);
    we <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, e);
    @(posedge clk);
    re <= 1'b1;
    ra <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    chk(rd, e, "read");
  endtask : reg_rd
  task automatic wait_code(input int n);
    repeat (16000) if (n_code < n) @(negedge clk);
    chk(n_code >= n, 1, "code wait");
  endtask : wait_code
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial forever #5 clk = ~clk;
  // link phase kept off every system clock edge
  initial
  begin
    #3;
    forever #40 lk = ~lk;
  end
  always @(posedge clk)
  begin : pixels
    logic [31:0] r;
    r = rnd();
    pix <= r[23:0];
    rgb <= r[31:8];
  end
  // per-line pulse lengths, counted in system clocks
  always @(posedge clk)
  begin
    n_hs += !hs;
    n_cl += cw;
    n_fm += fwe + fre;
  end
  initial
  begin
    #900000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(vof_pkg::OFF_PRIMARY_MODE, 8'h40);
    reg_rd(vof_pkg::OFF_THIRD_MODE, 8'h00);
    reg_rd(8'h7F, 8'h00);
    reg_rd(vof_pkg::OFF_STATUS, 8'h50);
    reg_wr(vof_pkg::OFF_PRIMARY_MODE, 8'h01);
    reg_rd(vof_pkg::OFF_PRIMARY_MODE, 8'h01);
    reg_rd(vof_pkg::OFF_STATUS, 8'h10);
    reg_wr(vof_pkg::OFF_CLAMP_CTRL, 8'h01);
    @(posedge clk);
    ls <= 1'b1;
    @(posedge clk);
    ls <= 1'b0;
    repeat (40) @(posedge clk);
    base = n_code;
    // one restart only: later lines run free so the gaps stay exact
    for (int i = 0; i < 5; i++)
    begin
      logic f, v;
      f = i[0];
      v = i[1] || (i == 4);
      h0 = n_hs;
      c0 = n_cl;
      w0 = n_fm;
      if (i == 4)
        reg_wr(vof_pkg::OFF_THIRD_MODE, 8'h08);
      @(posedge clk);
      fld <= f;
      vb <= v;
      vl <= (i == 4);
      vsi <= (i == 1);
      wait_code(base + 1);
      chk(code, exp_code(f, v && i != 4, 1'b1), "eav");
      chk(vsn, i != 2, "vsync");
      chk({wr, rr}, {i == 1, i == 2}, "memory reset");
      if (i > 0)
        chk(gap, 2 * 720, "active");
      b0 = bad;
      wait_code(base + 2);
      chk(code, exp_code(f, v && i != 4, 1'b0), "sav");
      chk(gap, 2 * 858 - 2 * 720 - 8, "blank");
      chk(bad, b0, "blank data");
      chk(n_hs - h0, vof_pkg::HSYNC_W_PX * CLK_PER_PX, "hsync width");
      chk(n_cl - c0, CLAMP_CLKS, "clamp window");
      if (i > 0)
        chk(n_fm - w0, v ? 0 : 2 * 720 * CLK_PER_PX, "memory strobes");
      base = n_code;
    end
    @(posedge clk);
    slp <= 1'b1;
    fm <= 1'b0;
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk(od, 0, "sleep data");
    chk(drc, 0, "sleep clock");
    chk({fwe, fre, wr, rr}, 0, "frame store off");
    @(posedge clk);
    slp <= 1'b0;
    vf <= 4'h5;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(vpin, 1, "vbi pin");
    reg_rd(vof_pkg::OFF_VBI_FLAGS, 8'h05);
    end_of_test();
  end
endmodule : vof_top_tb

// ### vof_trs.sv
// Purpose: fourth word of a timing reference code
// Assumes: flags are stable when the word is taken
// Notes: protection bits are the XOR form of the code table
module vof_trs
(
  input wire logic field_i,
  input wire logic vflag_i,
  input wire logic hflag_i,
  output logic [7:0] word_o
);
  assign word_o = {vof_pkg::TRS_FIXED_ONE, field_i, vflag_i, hflag_i,
                   vflag_i ^ hflag_i, field_i ^ hflag_i,
                   field_i ^ vflag_i, field_i ^ vflag_i ^ hflag_i};
endmodule : vof_trs
